// file: src/arci_top.sv
// Command interpreter: line collector, parser, responder and paced output
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Collect printable characters until carriage return
// - Drop line feed after the terminator
// - Command is one upper-case letter, optional number
// - Dollar prefix executes but sends nothing back
// - Every other command gets a CR-ended reply
// - Query reply is letter then requested value
// - Action reply is the letter alone
// - Bad or unexecutable command gives error reply
// - Error reply starts with question mark, echo
// - Control commands refused while in local
// - Reply waits while a panel button held
// - Serial port sends reply as soon as ready
// - GPIB holds reply until addressed to talk
// - Command bytes accepted until CR, then held off until the responder is idle
// - Pacing command slows reply characters
// - Status query reports local or remote
// - Host picks full lockout or live selector
// - Same parser for serial and GPIB
// - Power-up local, refusing host control
// - Terminator is code 13, LF harmless
////////////////////////////////////////////////////////////////////////////////
module arci_top #(
  parameter int unsigned PACE_UNIT_CYCLES = arci_pkg::PACE_UNIT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic            rx_ready,
  input  wire logic       gpib_active,
  input  wire logic       talk_addressed,
  input  wire logic       button_pin,
  input  wire logic       local_remote_selector,
  output logic            tx_valid,
  output logic      [7:0] tx_data,
  input  wire logic       tx_ready,
  output logic            exec_valid,
  output logic      [7:0] exec_letter,
  output logic     [15:0] exec_param,
  output logic            remote_mode,
  output logic            panel_locked
);
  localparam int unsigned LD = arci_pkg::LINE_DEPTH;
  localparam int unsigned RD = arci_pkg::RESP_DEPTH;

  logic [7:0]  line_mem [0:LD-1];
  logic [3:0]  len_r;
  logic        ovf_r;
  logic        quiet_r;
  logic        done_r;
  logic        rx_fire;
  logic        take_line;

  logic [7:0]  resp_mem [0:RD-1];
  logic [7:0]  resp_nxt [0:RD-1];
  logic [3:0]  rlen_r;
  logic [3:0]  rlen_nxt;
  logic [3:0]  idx_r;
  arci_pkg::arci_state_e st_r;

  logic        remote_r;
  logic        lock_r;
  logic [3:0]  pace_r;
  logic [7:0]  letter;
  logic [15:0] prm;
  logic        bad_char;
  logic        has_prm;
  logic        range_bad;
  logic        err;
  arci_pkg::arci_class_e cls;

  logic [2:0]  sync_r [0:1];
  logic [1:0]  pin_s_r;
  logic        sel_prev_r;
  logic        btn_s;
  logic        sel_rise;

  logic        f_in_valid;
  logic        f_in_ready;
  logic        f_out_valid;
  logic [7:0]  f_out_data;
  logic        pop;
  logic        tick;
  logic        permit_r;

  function automatic arci_pkg::arci_class_e classify(input logic [7:0] c);
    if (c == arci_pkg::CMD_STATUS)
      classify = arci_pkg::CL_QUERY;
    else if (c == arci_pkg::CMD_CONTROL || c == arci_pkg::CMD_PACE)
      classify = arci_pkg::CL_FREE;
    else if (c >= arci_pkg::CH_UPPER_A && c <= arci_pkg::CH_UPPER_Z
             && arci_pkg::CTRL_LETTERS[5'(c - arci_pkg::CH_UPPER_A)])
      classify = arci_pkg::CL_CTRL;
    else
      classify = arci_pkg::CL_NONE;
  endfunction : classify

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a level counts once stages two and three agree
  for (genvar g = 0; g < 2; g++)
  begin : g_sync
    always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
      begin
        sync_r[g]  <= 3'h0;
        pin_s_r[g] <= 1'b0;
      end
      else
      begin
        sync_r[g]  <= {sync_r[g][1:0], g == 0 ? button_pin : local_remote_selector};
        if (sync_r[g][1] == sync_r[g][2])
          pin_s_r[g] <= sync_r[g][2];
      end
  end

  assign btn_s    = pin_s_r[0];
  assign sel_rise = pin_s_r[1] & ~sel_prev_r;

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      sel_prev_r <= 1'b0;
    else
      sel_prev_r <= pin_s_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Line collector, shared by both ports
  assign rx_fire   = rx_valid & rx_ready;
  assign take_line = (st_r == arci_pkg::ST_IDLE) & done_r;

  always_ff @(posedge sys_clk)
    if (rx_fire && rx_data != arci_pkg::CH_CR && rx_data != arci_pkg::CH_LF
        && !(len_r == 4'h0 && !quiet_r && rx_data == arci_pkg::CH_DOLLAR)
        && len_r < 4'(LD))
      line_mem[len_r[2:0]] <= rx_data;

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      len_r   <= 4'h0;
      ovf_r   <= 1'b0;
      quiet_r <= 1'b0;
      done_r  <= 1'b0;
    end
    else if (take_line)
    begin
      len_r   <= 4'h0;
      ovf_r   <= 1'b0;
      quiet_r <= 1'b0;
      done_r  <= 1'b0;
    end
    else if (rx_fire && rx_data != arci_pkg::CH_LF)
    begin
      if (rx_data == arci_pkg::CH_CR)
        done_r <= 1'b1;
      else if (len_r == 4'h0 && !quiet_r && rx_data == arci_pkg::CH_DOLLAR)
        quiet_r <= 1'b1;
      else if (len_r < 4'(LD))
        len_r <= len_r + 4'h1;
      else
        ovf_r <= 1'b1;
    end

  // Only a finished line waiting for the parser stalls the sender
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      rx_ready <= 1'b0;
    else
      rx_ready <= !((rx_fire && rx_data == arci_pkg::CH_CR) || (done_r && !take_line));

  ////////////////////////////////////////////////////////////////////////////
  // Parser
  always_comb
  begin
    letter   = line_mem[0];
    prm      = '0;
    bad_char = 1'b0;
    for (int i = 1; i < LD; i++)
      if (4'(i) < len_r)
      begin
        if (line_mem[i] >= arci_pkg::CH_ZERO && line_mem[i] <= arci_pkg::CH_NINE)
          prm = 16'(prm * 16'd10 + 16'(line_mem[i] - arci_pkg::CH_ZERO));
        else
          bad_char = 1'b1;
      end
    has_prm = len_r > 4'h1;
    cls     = classify(letter);
    case (letter)
      arci_pkg::CMD_CONTROL: range_bad = !has_prm || prm > arci_pkg::CONTROL_MAX;
      arci_pkg::CMD_PACE:    range_bad = !has_prm || prm > arci_pkg::PACE_MAX;
      arci_pkg::CMD_STATUS:  range_bad = has_prm;
      default:               range_bad = 1'b0;
    endcase
    err = ovf_r || len_r == 4'h0 || cls == arci_pkg::CL_NONE || bad_char
          || range_bad || (cls == arci_pkg::CL_CTRL && !remote_r);
  end

  // Reply image: error echo, status value, or letter alone
  always_comb
  begin
    for (int i = 0; i < RD; i++)
      resp_nxt[i] = arci_pkg::CH_CR;
    if (err)
    begin
      resp_nxt[0] = arci_pkg::CH_QMARK;
      for (int i = 0; i < LD; i++)
        if (4'(i) < len_r)
          resp_nxt[i+1] = line_mem[i];
      rlen_nxt = 4'(len_r + 4'h2);
    end
    else if (cls == arci_pkg::CL_QUERY)
    begin
      resp_nxt[0] = letter;
      resp_nxt[1] = arci_pkg::CH_ZERO | {7'h0, remote_r};
      resp_nxt[2] = arci_pkg::CH_ZERO | {7'h0, lock_r};
      rlen_nxt    = 4'h4;
    end
    else
    begin
      resp_nxt[0] = letter;
      rlen_nxt    = 4'h2;
    end
  end

  always_ff @(posedge sys_clk)
    if (take_line)
      resp_mem <= resp_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      remote_r <= arci_pkg::RESET_REMOTE;
      lock_r   <= arci_pkg::RESET_LOCK;
      pace_r   <= arci_pkg::RESET_PACE;
    end
    else if (take_line && !err && letter == arci_pkg::CMD_CONTROL)
    begin
      remote_r <= prm[0];
      lock_r   <= prm == 16'h0001;
    end
    else if (take_line && !err && letter == arci_pkg::CMD_PACE)
      pace_r <= prm[3:0];
    else if (sel_rise && remote_r && !lock_r)
      remote_r <= 1'b0;

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      exec_valid   <= 1'b0;
      exec_letter  <= 8'h00;
      exec_param   <= 16'h0000;
      remote_mode  <= arci_pkg::RESET_REMOTE;
      panel_locked <= arci_pkg::RESET_LOCK;
    end
    else
    begin
      exec_valid   <= take_line && !err && cls == arci_pkg::CL_CTRL;
      remote_mode  <= remote_r;
      panel_locked <= lock_r;
      if (take_line)
      begin
        exec_letter <= letter;
        exec_param  <= prm;
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // Responder
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      st_r   <= arci_pkg::ST_IDLE;
      idx_r  <= 4'h0;
      rlen_r <= 4'h0;
    end
    else
      case (st_r)
        arci_pkg::ST_IDLE:
          if (take_line)
          begin
            rlen_r <= rlen_nxt;
            idx_r  <= 4'h0;
            if (!quiet_r)
              st_r <= arci_pkg::ST_WAIT;
          end
        arci_pkg::ST_WAIT:
          if (!btn_s && (!gpib_active || talk_addressed))
            st_r <= arci_pkg::ST_SEND;
        arci_pkg::ST_SEND:
          if (f_in_ready)
          begin
            idx_r <= idx_r + 4'h1;
            if (idx_r == 4'(rlen_r - 4'h1))
              st_r <= arci_pkg::ST_IDLE;
          end
        default:
          st_r <= arci_pkg::ST_IDLE;
      endcase

  assign f_in_valid = st_r == arci_pkg::ST_SEND;

  arci_fifo #(
    .WIDTH (arci_pkg::BYTE_W),
    .DEPTH (arci_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (f_in_valid),
    .in_data   (resp_mem[idx_r]),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (pop)
  );

  arci_pace #(
    .UNIT_CYCLES (PACE_UNIT_CYCLES)
  ) u_pace (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pace    (pace_r),
    .tick    (tick)
  );

  // A missed tick is kept as a permit so a stalled byte still goes
  assign pop = f_out_valid && (!tx_valid || tx_ready) && permit_r;

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      permit_r <= 1'b0;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end
    else
    begin
      permit_r <= tick || (permit_r && !pop);
      if (pop)
      begin
        tx_valid <= 1'b1;
        tx_data  <= f_out_data;
      end
      else if (tx_ready)
        tx_valid <= 1'b0;
    end

  ////////////////////////////////////////////////////////////////////////////
  property p_cr_ends;
    @(posedge sys_clk) disable iff (!rst_b)
    rx_fire && rx_data == arci_pkg::CH_CR |=> done_r && !rx_ready;
  endproperty
  a_cr_ends: assert property (p_cr_ends) else $error("CR did not end line");

  property p_lf_drop;
    @(posedge sys_clk) disable iff (!rst_b)
    rx_fire && rx_data == arci_pkg::CH_LF |=> $stable(len_r) && !done_r;
  endproperty
  a_lf_drop: assert property (p_lf_drop) else $error("LF changed line");

  property p_quiet;
    @(posedge sys_clk) disable iff (!rst_b)
    take_line && quiet_r |=> st_r == arci_pkg::ST_IDLE [*2];
  endproperty
  a_quiet: assert property (p_quiet) else $error("Quiet command replied");

  property p_query;
    @(posedge sys_clk) disable iff (!rst_b)
    take_line && !err && cls == arci_pkg::CL_QUERY
      |=> resp_mem[0] == $past(letter) && rlen_r == 4'h4 && resp_mem[3] == arci_pkg::CH_CR;
  endproperty
  a_query: assert property (p_query) else $error("Bad query reply");

  property p_action;
    @(posedge sys_clk) disable iff (!rst_b)
    take_line && !err && cls != arci_pkg::CL_QUERY |=> rlen_r == 4'h2 && resp_mem[1] == arci_pkg::CH_CR;
  endproperty
  a_action: assert property (p_action) else $error("Bad action reply");

  property p_error;
    @(posedge sys_clk) disable iff (!rst_b)
    take_line && err |=> resp_mem[0] == arci_pkg::CH_QMARK && rlen_r == 4'($past(len_r) + 4'h2);
  endproperty
  a_error: assert property (p_error) else $error("Bad error reply");

  property p_local;
    @(posedge sys_clk) disable iff (!rst_b)
    take_line && cls == arci_pkg::CL_CTRL && !remote_r |=> !exec_valid ##1 !exec_valid;
  endproperty
  a_local: assert property (p_local) else $error("Control ran in local");

  property p_button;
    @(posedge sys_clk) disable iff (!rst_b)
    st_r == arci_pkg::ST_WAIT && btn_s |=> st_r == arci_pkg::ST_WAIT;
  endproperty
  a_button: assert property (p_button) else $error("Reply sent while button held");

  property p_serial;
    @(posedge sys_clk) disable iff (!rst_b)
    st_r == arci_pkg::ST_WAIT && !btn_s && !gpib_active |=> st_r == arci_pkg::ST_SEND;
  endproperty
  a_serial: assert property (p_serial) else $error("Serial reply late");

  property p_gpib;
    @(posedge sys_clk) disable iff (!rst_b)
    st_r == arci_pkg::ST_WAIT && gpib_active && !talk_addressed |=> st_r == arci_pkg::ST_WAIT;
  endproperty
  a_gpib: assert property (p_gpib) else $error("GPIB reply without talk");
endmodule : arci_top
`default_nettype wire

// file: include/arci_pkg.sv
// Shared constants and types for the ASCII command interpreter
package arci_pkg;

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned LINE_DEPTH = 8;
  localparam int unsigned RESP_DEPTH = 10;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned PARAM_W    = 16;

  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_QMARK  = 8'h3f;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_NINE   = 8'h39;
  localparam logic [7:0] CH_UPPER_A = 8'h41;
  localparam logic [7:0] CH_UPPER_Z = 8'h5a;

  localparam logic [7:0] CMD_CONTROL = 8'h43;
  localparam logic [7:0] CMD_PACE    = 8'h57;
  localparam logic [7:0] CMD_STATUS  = 8'h58;
  // One bit per letter A..Z, set where the letter is a control action
  localparam logic [25:0] CTRL_LETTERS = 26'h00c93a1;

  localparam logic [15:0] CONTROL_MAX = 16'h0003;
  localparam logic [15:0] PACE_MAX    = 16'h0009;

  localparam logic       RESET_REMOTE = 1'b0;
  localparam logic       RESET_LOCK   = 1'b0;
  localparam logic [3:0] RESET_PACE   = 4'h0;

  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned PACE_UNIT_US  = 1000;
  localparam int unsigned PACE_UNIT_CYC = (PACE_UNIT_US * 1000000) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEND} arci_state_e;
  typedef enum logic [1:0] {CL_NONE, CL_QUERY, CL_FREE, CL_CTRL} arci_class_e;

endpackage : arci_pkg

// file: src/arci_fifo.sv
// Small ready/valid byte FIFO between responder and transmitter
`timescale 1ns/1ps
`default_nettype none
module arci_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = count_r < (PW+1)'(DEPTH);
  assign out_valid = count_r != '0;
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : step

  always_ff @(posedge sys_clk)
    if (push)
      mem[wr_ptr_r] <= in_data;

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= step(wr_ptr_r);
      if (pop)
        rd_ptr_r <= step(rd_ptr_r);
      count_r <= (PW+1)'(count_r + push - pop);
    end
endmodule : arci_fifo
`default_nettype wire

// file: src/arci_pace.sv
// Pacing divider: one enable pulse per pace step of output bytes
`timescale 1ns/1ps
`default_nettype none
module arci_pace #(
  parameter int unsigned UNIT_CYCLES = arci_pkg::PACE_UNIT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] pace,
  output logic            tick
);
  logic [31:0] unit_cnt_r;
  logic [3:0]  step_cnt_r;
  logic        unit_end;

  assign unit_end = unit_cnt_r == 32'(UNIT_CYCLES - 1);

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      unit_cnt_r <= '0;
      step_cnt_r <= '0;
      tick       <= 1'b0;
    end
    else if (pace == 4'h0)
    begin
      unit_cnt_r <= '0;
      step_cnt_r <= '0;
      tick       <= 1'b1;
    end
    else
    begin
      unit_cnt_r <= unit_end ? '0 : unit_cnt_r + 32'd1;
      tick       <= 1'b0;
      if (unit_end)
      begin
        if (step_cnt_r >= 4'(pace - 4'h1))
        begin
          step_cnt_r <= '0;
          tick       <= 1'b1;
        end
        else
          step_cnt_r <= step_cnt_r + 4'h1;
      end
    end
endmodule : arci_pace
`default_nettype wire

// file: tb/arci_host_model.sv
// Host-side reply sink: accepts reply bytes at full rate or stalls
`timescale 1ns/1ps
`default_nettype none
module arci_host_model (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic slow,
  output logic      tx_ready
);
  logic [1:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Slow host takes one byte in four, so replies back up into the FIFO
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r    <= 2'h0;
      tx_ready <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_r + 2'h1;
      tx_ready <= !slow || (cnt_r == 2'h3);
    end
  end
endmodule : arci_host_model
`default_nettype wire

// file: tb/ascii_remote_command_interpreter_tb.sv
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module ascii_remote_command_interpreter_tb;
  typedef struct { string cmd; string exp; int ex; } arci_row_s;
  localparam int unsigned N_ROWS = 15;
  arci_row_s rows [N_ROWS] = '{
    '{"X\015", "X00\015", 0}, '{"A\015", "?A\015", 0}, '{"C1\015", "C\015", 0},
    '{"X\015\012", "X11\015", 0}, '{"A5\015", "A\015", 1}, '{"C3\015", "C\015", 0},
    '{"X\015", "X10\015", 0}, '{"Z\015", "?Z\015", 0}, '{"C7\015", "?C7\015", 0},
    '{"C\015", "?C\015", 0}, '{"a\015", "?a\015", 0},
    '{"A123456789\015", "?A1234567\015", 0}, '{"$T42\015", "", 1},
    '{"$Q\015", "", 0}, '{"W0\015", "W\015", 0}};
  string      ctl = "AFHIJMPST";
  logic       sys_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic       gpib_active = 1'b0;
  logic       talk_addressed = 1'b0;
  logic       button_pin = 1'b0;
  logic       local_remote_selector = 1'b0;
  logic       slow = 1'b0;
  logic       rx_ready, tx_valid, tx_ready, exec_valid, remote_mode, panel_locked;
  logic [7:0] tx_data, exec_letter, ex_letter;
  logic [15:0] exec_param, ex_param;
  logic [7:0] q [$];
  int         t_q [$];
  int         cyc = 0;
  int         exec_cnt = 0;
  int         n0;
  int         err_total = 0;
  int         checks = 0;

  always #2.5 sys_clk = ~sys_clk;

  arci_top #(.PACE_UNIT_CYCLES(4)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .gpib_active(gpib_active), .talk_addressed(talk_addressed),
    .button_pin(button_pin), .local_remote_selector(local_remote_selector),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .exec_valid(exec_valid), .exec_letter(exec_letter), .exec_param(exec_param),
    .remote_mode(remote_mode), .panel_locked(panel_locked));

  arci_host_model i_host (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow), .tx_ready(tx_ready));

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    cyc++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      q.push_back(tx_data);
      t_q.push_back(cyc);
    end
    if (exec_valid === 1'b1)
    begin
      exec_cnt++;
      ex_letter = exec_letter;
      ex_param  = exec_param;
    end
    // Generous ceiling, the whole sequence needs well under two thousand cycles
    if (cyc == 40000)
    begin
      err_total++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // Valid stays up across the bytes of one line, dropped once after the last
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      rx_valid <= 1'b1;
      rx_data  <= s[i];
      @(posedge sys_clk);
      while (rx_ready !== 1'b1)
        @(posedge sys_clk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask : send_line

  task automatic get_reply(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      if (q.size() > 0 && q[q.size() - 1] === 8'h0d)
        break;
    end
  endtask : get_reply

  task automatic cmp_reply(input string exp);
    check("reply length", 16'(q.size()), 16'(exp.len()));
    for (int i = 0; i < exp.len() && i < q.size(); i++)
      check("reply byte", {8'h00, q[i]}, {8'h00, exp[i]});
    q.delete();
  endtask : cmp_reply

  task automatic run_cmd(input string cmd, input string exp);
    send_line(cmd);
    get_reply(400);
    cmp_reply(exp);
  endtask : run_cmd

  task automatic pulse_selector;
    local_remote_selector <= 1'b1;
    repeat (12) @(posedge sys_clk);
    local_remote_selector <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : pulse_selector

  task automatic finish_test;
    $display("checks %0d, err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge sys_clk);
    check("reset remote", {15'h0, remote_mode}, 16'h0000);
    check("reset rx_ready", {15'h0, rx_ready}, 16'h0000);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    foreach (rows[i])
    begin
      n0 = exec_cnt;
      send_line(rows[i].cmd);
      get_reply(rows[i].exp.len() == 0 ? 60 : 400);
      cmp_reply(rows[i].exp);
      check("exec count", 16'(exec_cnt - n0), 16'(rows[i].ex));
    end
    check("exec letter", {8'h00, ex_letter}, 16'h0054);
    check("exec param", ex_param, 16'h002a);
    for (int i = 0; i < ctl.len(); i++)
    begin
      n0 = exec_cnt;
      run_cmd({ctl.substr(i, i), "\015"}, {ctl.substr(i, i), "\015"});
      check("exec count", 16'(exec_cnt - n0), 16'h0001);
    end
    // Held reply must wait for the talk address
    gpib_active <= 1'b1;
    send_line("X\015");
    get_reply(80);
    check("gpib held", 16'(q.size()), 16'h0000);
    talk_addressed <= 1'b1;
    get_reply(400);
    cmp_reply("X10\015");
    talk_addressed <= 1'b0;
    gpib_active    <= 1'b0;
    button_pin     <= 1'b1;
    repeat (10) @(posedge sys_clk);
    send_line("X\015");
    get_reply(80);
    check("button held", 16'(q.size()), 16'h0000);
    button_pin <= 1'b0;
    get_reply(400);
    cmp_reply("X10\015");
    run_cmd("W1\015", "W\015");
    t_q.delete();
    send_line("X\015");
    get_reply(400);
    // First byte may ride a stored permit, so time bytes two to four only
    check("paced span", 16'(t_q[3] - t_q[1]), 16'h0008);
    t_q.delete();
    cmp_reply("X10\015");
    run_cmd("W0\015", "W\015");
    slow <= 1'b1;
    run_cmd("X\015", "X10\015");
    slow <= 1'b0;
    pulse_selector();
    check("selector local", {15'h0, remote_mode}, 16'h0000);
    run_cmd("C1\015", "C\015");
    check("locked", {15'h0, panel_locked}, 16'h0001);
    pulse_selector();
    check("lockout", {15'h0, remote_mode}, 16'h0001);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("rst remote", {15'h0, remote_mode}, 16'h0000);
    check("rst lock", {15'h0, panel_locked}, 16'h0000);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    run_cmd("A\015", "?A\015");
    finish_test();
  end
endmodule : ascii_remote_command_interpreter_tb
`default_nettype wire
